// *** verilog/conv_ctrl_pkg.sv ***
/*
 * constants, types and pin bundles for the conversion-control block
 * assumes a single 200 MHz clock and an analog core that streams eight results per conversion
 */
package conv_ctrl_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLOCK_PERIOD_PS       = 5000;
	localparam int CONV_TIME_MAX_NS      = 4000;  // plain default, longest conversion
	localparam int CONV_TIME_MAX_CYCLES  = (CONV_TIME_MAX_NS * 1000) / CLOCK_PERIOD_PS;
	localparam int CONV_CNT_W            = 12;

	// ==========================================================
	// channel layout
	localparam int CHANNELS              = 8;
	localparam int RESULT_W              = 16;
	localparam int CH_IDX_W              = 3;
	localparam int STEP_W                = 4;
	localparam int FIFO_DEPTH            = 32;
	localparam int LOW_PINS_W            = 7;
	localparam int SYNC_W                = 9;

	// ==========================================================
	// reset values
	localparam logic [SYNC_W-1:0] PIN_RESET_VALUE = 9'h03C;  // strobes, power request and range idle high, starts low

	// ==========================================================
	// bundles
	typedef struct packed {
		logic border;   // byte_order_select
		logic bsel;     // byte_serial_select
		logic isel;     // interface_select
		logic range;
		logic pd_n;     // powerdown_request_n
		logic rd_n;
		logic cs_n;
		logic start_b;
		logic start_a;
	} pins_type;

	typedef struct packed {
		logic                  oe;
		logic [LOW_PINS_W-1:0] low;
		logic                  msb;
	} bus_drive_type;

	typedef enum logic [1:0] {
		READ_PARALLEL,
		READ_BYTE,
		READ_SERIAL
	} read_mode_type;

	typedef enum {
		CONV_IDLE,
		CONV_RUN
	} conv_state_type;

	typedef enum {
		PWR_ON,
		PWR_STANDBY,
		PWR_SHUTDOWN
	} pwr_state_type;

endpackage : conv_ctrl_pkg

// *** verilog/sim_sample_conversion_ctrl.sv ***
/*
 * result fifo and conversion-control top: sample starts, busy, power-down, parallel and byte readout
 * assumes the analog core converts on conv_request and pushes eight results, channel 1 first
 */
`timescale 1ns/1ps

// ==========================================================
// Function
// - full parallel: bits six to zero of channel on low pins while strobes low.
// - byte mode: low pins plus msb pin give each result in two reads.
// - power request low: standby if range high, shutdown if range low.
// - power-down entry happens at any time, even mid conversion.
// - standby powers front end off; shutdown powers everything off.
// - combined start rising edge samples all eight channels together.
// - busy rises at conversion start and lasts at most the maximum conversion time.
// - busy falls when done and result registers update together.
// - after a completed conversion, reads present channel 1 then ascending channels.
// - all eight channels always converted and read; unused inputs tied off.
// - first-channel flag high for channel 1 reads (both in byte mode), low from channel 2 read.
// - strobes high after reading: bus and flag released.
// - group a edge holds channels 1-4; conversion waits for group b.
// - group b edge holds channels 5-8; both seen starts conversion, busy rises.
// - reads during busy return previous results; after, current ones.
// - interface select low parallel; high gives byte or serial by second pin.
// - byte order pin high sends upper byte first, low lower byte.

// ==========================================================
// result fifo
module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem[rd_ptr_r];

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule : result_fifo

// ==========================================================
// top
module sim_sample_conversion_ctrl
	import conv_ctrl_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	input  wire logic                  group_a_sample_start,
	input  wire logic                  group_b_sample_start,
	input  wire logic                  cs_n,
	input  wire logic                  rd_n,
	input  wire logic                  powerdown_request_n,
	input  wire logic                  range_select,
	input  wire logic                  interface_select,
	input  wire logic                  byte_serial_select,
	input  wire logic                  byte_order_select,
	input  wire logic                  core_valid,
	input  wire logic [RESULT_W-1:0]   core_data,
	output logic                       core_ready,
	output logic                       conv_request,
	output logic                       hold_group_a,
	output logic                       hold_group_b,
	output logic                       busy,
	output logic                       front_end_power_down,
	output logic                       reference_power_down,
	output logic [LOW_PINS_W-1:0]      low_data_pins_out,
	output logic                       low_data_pins_oe,
	output logic                       byte_msb_pin_out,
	output logic                       byte_msb_pin_oe,
	output logic                       first_channel_flag_out,
	output logic                       first_channel_flag_oe
);

	// ==========================================================
	// pin synchronisers: three stages, change accepted when stages two and three agree
	pins_type              raw;
	logic [SYNC_W-1:0]     s1_r;
	logic [SYNC_W-1:0]     s2_r;
	logic [SYNC_W-1:0]     s3_r;
	pins_type              pin_r;
	pins_type              pin_prev_r;

	assign raw = '{border: byte_order_select, bsel: byte_serial_select, isel: interface_select,
		range: range_select, pd_n: powerdown_request_n, rd_n: rd_n, cs_n: cs_n,
		start_b: group_b_sample_start, start_a: group_a_sample_start};

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s1_r       <= PIN_RESET_VALUE;
			s2_r       <= PIN_RESET_VALUE;
			s3_r       <= PIN_RESET_VALUE;
			pin_r      <= PIN_RESET_VALUE;
			pin_prev_r <= PIN_RESET_VALUE;
		end else begin
			s1_r       <= raw;
			s2_r       <= s1_r;
			s3_r       <= s2_r;
			pin_r      <= pins_type'((s2_r & s3_r) | (pin_r & (s2_r | s3_r)));
			pin_prev_r <= pin_r;
		end
	end

	logic a_rise;
	logic b_rise;
	logic cs_fall;
	logic rd_fall;
	logic read_strobe;
	logic strobes_low;

	assign a_rise      = pin_r.start_a & ~pin_prev_r.start_a;
	assign b_rise      = pin_r.start_b & ~pin_prev_r.start_b;
	assign cs_fall     = ~pin_r.cs_n & pin_prev_r.cs_n;
	assign rd_fall     = ~pin_r.rd_n & pin_prev_r.rd_n;
	assign strobes_low = ~pin_r.cs_n & ~pin_r.rd_n;
	// tied strobes fall together; separate ones count on rd while cs is low
	assign read_strobe = (rd_fall | cs_fall) & strobes_low;

	// ==========================================================
	// power-down
	pwr_state_type pwr_r;
	logic          powered;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pwr_r <= PWR_ON;
		end else if (!pin_r.pd_n) begin
			pwr_r <= pin_r.range ? PWR_STANDBY : PWR_SHUTDOWN;
		end else begin
			pwr_r <= PWR_ON;  // settling wait after exit is left to the host
		end
	end

	assign powered = (pwr_r == PWR_ON);

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			front_end_power_down <= 1'b0;
			reference_power_down <= 1'b0;
		end else begin
			front_end_power_down <= (pwr_r != PWR_ON);
			reference_power_down <= (pwr_r == PWR_SHUTDOWN);
		end
	end

	// ==========================================================
	// sample and conversion control
	conv_state_type             conv_r;
	logic                       held_a_r;
	logic                       held_b_r;
	logic                       go;
	logic [CONV_CNT_W-1:0]      conv_cnt_r;
	logic [CH_IDX_W:0]          got_r;
	logic                       done;
	logic                       fifo_valid;
	logic [RESULT_W-1:0]        fifo_data;
	logic                       drain;
	logic [RESULT_W-1:0]        pending_r [CHANNELS];
	logic [RESULT_W-1:0]        current_r [CHANNELS];
	logic                       fifo_in_ready;
	localparam int              OCC_W = $clog2(FIFO_DEPTH) + 1;
	logic [OCC_W-1:0]           occ_r;
	logic [OCC_W-1:0]           occ_nxt;

	// core_ready is registered, so it looks one word ahead; a push at full would be lost
	assign occ_nxt = occ_r + OCC_W'(core_valid & core_ready & fifo_in_ready) - OCC_W'(drain);

	// a tied start gives both edges in one cycle, so all channels hold together
	assign go    = powered && (conv_r == CONV_IDLE) && (held_a_r | a_rise) && (held_b_r | b_rise);
	assign drain = (conv_r == CONV_RUN) && fifo_valid && (got_r != (CH_IDX_W+1)'(CHANNELS));
	assign done  = (conv_r == CONV_RUN) &&
		((got_r == (CH_IDX_W+1)'(CHANNELS)) || (conv_cnt_r == CONV_CNT_W'(CONV_TIME_MAX_CYCLES - 1)));

	always_ff @(posedge clock) begin
		if (!rst_b || !powered) begin
			held_a_r <= 1'b0;
			held_b_r <= 1'b0;
		end else if (go) begin
			held_a_r <= 1'b0;
			held_b_r <= 1'b0;
		end else if (conv_r == CONV_IDLE) begin  // edges during busy dropped
			held_a_r <= held_a_r | a_rise;  // waits for group b
			held_b_r <= held_b_r | b_rise;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b || !powered) begin
			conv_r     <= CONV_IDLE;  // power-down aborts a conversion
			conv_cnt_r <= '0;
			got_r      <= '0;
		end else if (go) begin
			conv_r     <= CONV_RUN;
			conv_cnt_r <= '0;
			got_r      <= '0;
		end else if (done) begin
			conv_r <= CONV_IDLE;
		end else if (conv_r == CONV_RUN) begin
			conv_cnt_r <= conv_cnt_r + 1'b1;
			if (drain) begin
				got_r <= got_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			busy         <= 1'b0;
			conv_request <= 1'b0;
			hold_group_a <= 1'b0;
			hold_group_b <= 1'b0;
			core_ready   <= 1'b0;
			occ_r        <= '0;
		end else begin
			occ_r        <= occ_nxt;
			busy         <= powered && (go || ((conv_r == CONV_RUN) && !done));
			conv_request <= go;
			hold_group_a <= powered && (held_a_r || a_rise || ((conv_r == CONV_RUN) && !done));
			hold_group_b <= powered && (held_b_r || b_rise || ((conv_r == CONV_RUN) && !done));
			core_ready   <= (occ_nxt != OCC_W'(FIFO_DEPTH));
		end
	end

	// every channel lands in the bank, unused ones too
	always_ff @(posedge clock) begin
		if (drain) begin
			pending_r[got_r[CH_IDX_W-1:0]] <= fifo_data;
		end
	end

	// readout bank only moves at the end, so reads during busy see the old sample
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int i = 0; i < CHANNELS; i++) begin
				current_r[i] <= '0;
			end
		end else if (done) begin
			for (int i = 0; i < CHANNELS; i++) begin
				current_r[i] <= pending_r[i];
			end
		end
	end

	result_fifo #(
		.WIDTH (RESULT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst_b     (rst_b),
		.in_valid  (core_valid & core_ready),
		.in_ready  (fifo_in_ready),
		.in_data   (core_data),
		.out_valid (fifo_valid),
		.out_ready (drain),
		.out_data  (fifo_data)
	);

	// ==========================================================
	// readout
	read_mode_type          mode;
	logic [STEP_W-1:0]      step_r;
	logic [STEP_W-1:0]      shown_r;
	bus_drive_type          drive;
	logic [RESULT_W-1:0]    word;
	logic                   upper;
	logic                   first;

	assign mode = !pin_r.isel ? READ_PARALLEL : (pin_r.bsel ? READ_BYTE : READ_SERIAL);

	// pointer restarts at channel 1 when busy falls at done
	always_ff @(posedge clock) begin
		if (!rst_b || done) begin
			step_r  <= '0;
			shown_r <= '0;
		end else if (read_strobe && mode != READ_SERIAL) begin
			shown_r <= step_r;
			if (mode == READ_BYTE) begin
				step_r <= step_r + 1'b1;  // two reads per channel
			end else begin
				step_r <= step_r + STEP_W'(2);
			end
		end
	end

	always_comb begin
		word  = current_r[shown_r[STEP_W-1:1]];
		// order pin picks which half goes out on the first read of a pair
		upper = shown_r[0] ^ pin_r.border;
		first = (shown_r[STEP_W-1:1] == '0);
		drive = '{oe: 1'b0, low: '0, msb: 1'b0};
		unique case (mode)
			READ_PARALLEL: begin
				drive = '{oe: strobes_low, low: word[6:0], msb: word[7]};
			end
			READ_BYTE: begin
				drive.oe  = strobes_low;
				drive.low = upper ? word[14:8] : word[6:0];
				drive.msb = upper ? word[15] : word[7];
			end
			READ_SERIAL: begin
				drive.oe = 1'b0;  // pins left to the outside party
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			low_data_pins_out      <= '0;
			low_data_pins_oe       <= 1'b0;
			byte_msb_pin_out       <= 1'b0;
			byte_msb_pin_oe        <= 1'b0;
			first_channel_flag_out <= 1'b0;
			first_channel_flag_oe  <= 1'b0;
		end else begin
			// released as soon as cs and rd rise again
			low_data_pins_out      <= drive.low;
			low_data_pins_oe       <= drive.oe;
			byte_msb_pin_out       <= drive.msb;
			byte_msb_pin_oe        <= drive.oe;
			first_channel_flag_out <= first && !pin_r.cs_n && (mode != READ_SERIAL) && (step_r != '0);
			first_channel_flag_oe  <= !pin_r.cs_n && (mode != READ_SERIAL) && (step_r != '0);
		end
	end

endmodule : sim_sample_conversion_ctrl

// *** verif/conv_ctrl_asserts.sv ***
/*
 * concurrent checks on the conversion-control top ports
 * assumes one clock and a synchronous active-low reset
 */
`timescale 1ns/1ps
module conv_ctrl_asserts
	import conv_ctrl_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic rd_n,
	input wire logic conv_request,
	input wire logic busy,
	input wire logic hold_group_a,
	input wire logic hold_group_b,
	input wire logic front_end_power_down,
	input wire logic reference_power_down,
	input wire logic low_data_pins_oe,
	input wire logic byte_msb_pin_oe,
	input wire logic first_channel_flag_out,
	input wire logic first_channel_flag_oe
);
	// ==========================================================
	// busy length
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic [CONV_CNT_W-1:0] busy_cnt_r;
	always_ff @(posedge clock) begin
		if (!rst_b || !busy)
			busy_cnt_r <= '0;
		else
			busy_cnt_r <= busy_cnt_r + 1'b1;
	end
	// ==========================================================
	// properties
	a_req_holds: assert property (conv_request |-> busy && hold_group_a && hold_group_b)
		else $error("conv request without busy and holds");
	a_req_pulse: assert property (conv_request |=> !conv_request)
		else $error("conv request longer than one cycle");
	a_busy_cause: assert property ($rose(busy) |-> conv_request)
		else $error("busy rose without conv request");
	a_busy_bound: assert property (busy_cnt_r <= CONV_TIME_MAX_CYCLES + 1)
		else $error("busy beyond max conversion time");
	a_busy_holds: assert property (busy |-> hold_group_a && hold_group_b)
		else $error("busy without both groups held");
	a_end_release: assert property ($fell(busy) |-> !hold_group_a && !hold_group_b)
		else $error("holds kept after busy fell");
	a_shut_all: assert property (reference_power_down |-> front_end_power_down)
		else $error("reference down while front end up");
	a_pd_abort: assert property (front_end_power_down |=> !busy)
		else $error("busy during power-down");
	a_rd_release: assert property (rd_n [*8] |-> !low_data_pins_oe)
		else $error("data pins driven with read strobe high");
	a_pins_pair: assert property (low_data_pins_oe == byte_msb_pin_oe)
		else $error("low pins and msb pin drive apart");
	a_flag_drive: assert property (first_channel_flag_out |-> first_channel_flag_oe)
		else $error("flag high but not driven");
	c_conv_done: cover property ($fell(busy));
	c_flag_high: cover property (first_channel_flag_out);
	c_shutdown: cover property (reference_power_down);
endmodule : conv_ctrl_asserts

bind sim_sample_conversion_ctrl conv_ctrl_asserts asserts_i (.*);

// *** verif/core_model.sv ***
/*
 * analog core stand-in: eight words per conv_request, word k = {~k, k}
 * assumes push on valid and ready; stall holds off new words, flood adds 32
 */
`timescale 1ns/1ps
module core_model
	import conv_ctrl_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          rst_b,
	input  wire logic          conv_request,
	input  wire logic          core_ready,
	input  wire logic          stall,
	input  wire logic          flood,
	output logic               core_valid,
	output logic [RESULT_W-1:0] core_data,
	output int                 push_cnt
);
	// ==========================================================
	// word stream
	int   pend;
	logic push;
	assign push = core_valid && core_ready;
	// released bus shows the inverse, never a stale copy
	assign core_data = core_valid ? {~push_cnt[7:0], push_cnt[7:0]} : {push_cnt[7:0], ~push_cnt[7:0]};
	always @(posedge clock) begin
		if (!rst_b) begin
			pend <= 0;
			push_cnt <= 0;
			core_valid <= 1'b0;
		end else begin
			pend <= pend - push + (conv_request ? 8 : 0) + (flood ? 32 : 0);
			push_cnt <= push_cnt + push;
			core_valid <= (core_valid && !push) || (!stall && pend - push > 0);
		end
	end
endmodule : core_model

// *** verif/testbench.sv ***
/*
 * self-checking bench for the conversion-control top
 * assumes the core model feeds results; strobes and mode pins driven here
 */
`timescale 1ns/1ps
module testbench;
	import conv_ctrl_pkg::*;
	logic clock, rst_b, sa, sb, cs_n, rd_n, pd_n, rng, isel, bsel, bord, stall, flood;
	logic cv, cr, creq, ha, hb, busy, fe, rf, loe, mo, moe, fo, foe;
	logic [6:0]  lo;
	logic [15:0] cd;
	int          pc;
	int          err_total = 0;
	int          check_count = 0;
	int          nconv = 0;

	sim_sample_conversion_ctrl dut (.clock(clock), .rst_b(rst_b), .group_a_sample_start(sa),
		.group_b_sample_start(sb), .cs_n(cs_n), .rd_n(rd_n), .powerdown_request_n(pd_n),
		.range_select(rng), .interface_select(isel), .byte_serial_select(bsel),
		.byte_order_select(bord), .core_valid(cv), .core_data(cd), .core_ready(cr),
		.conv_request(creq), .hold_group_a(ha), .hold_group_b(hb), .busy(busy),
		.front_end_power_down(fe), .reference_power_down(rf), .low_data_pins_out(lo),
		.low_data_pins_oe(loe), .byte_msb_pin_out(mo), .byte_msb_pin_oe(moe),
		.first_channel_flag_out(fo), .first_channel_flag_oe(foe));
	core_model core (.clock(clock), .rst_b(rst_b), .conv_request(creq), .core_ready(cr),
		.stall(stall), .flood(flood), .core_valid(cv), .core_data(cd), .push_cnt(pc));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// ==========================================================
	// helpers
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task automatic wait_on(input logic sel, input logic v);
		int n;
		n = 0;
		while ((sel ? cr : busy) !== v) begin
			cyc(1);
			n++;
			if (n > 2000) begin
				err_total++;
				test_done();
			end
		end
	endtask : wait_on
	task automatic start(input logic a, input logic b);
		@(posedge clock);
		sa <= a;
		sb <= b;
	endtask : start
	task automatic convert;
		start(1'b1, 1'b1);
		wait_on(1'b0, 1'b1);
		wait_on(1'b0, 1'b0);
		start(1'b0, 1'b0);
		cyc(6);
	endtask : convert
	function automatic logic [15:0] expw(input int k);
		return {~k[7:0], k[7:0]};
	endfunction : expw
	task automatic rd(input logic [7:0] e, input int f);
		@(posedge clock);
		rd_n <= 1'b0;
		cyc(8);
		chk({loe, mo, lo}, {1'b1, e});
		if (f >= 0)
			chk(fo, f[0]);
		@(posedge clock);
		rd_n <= 1'b1;
		cyc(8);
	endtask : rd
	task automatic frame(input int run, input logic bm, input logic ord);
		logic [15:0] w;
		@(posedge clock);
		cs_n <= 1'b0;
		for (int c = 0; c < 8; c++) begin
			w = expw(8 * run + c);
			if (!bm)
				rd(w[7:0], c == 0);
			else begin
				rd(ord ? w[15:8] : w[7:0], -1);
				rd(ord ? w[7:0] : w[15:8], -1);
			end
		end
		@(posedge clock);
		cs_n <= 1'b1;
		cyc(8);
		chk({loe, foe}, 2'b00);
	endtask : frame
	// ==========================================================
	// scenarios
	task automatic t_combined;
		start(1'b1, 1'b1);
		wait_on(1'b0, 1'b1);
		chk({ha, hb}, 2'b11);
		wait_on(1'b0, 1'b0);
		chk({ha, hb}, 2'b00);
		start(1'b0, 1'b0);
		frame(nconv++, 1'b0, 1'b0);
		$display("test combined done");
	endtask : t_combined
	task automatic t_groups;
		start(1'b1, 1'b0);
		cyc(20);
		chk({busy, ha, hb}, 3'b010);
		stall <= 1'b1;
		start(1'b1, 1'b1);
		wait_on(1'b0, 1'b1);
		chk({ha, hb}, 2'b11);
		start(1'b0, 1'b0);
		cyc(6);
		start(1'b1, 1'b1);
		@(posedge clock);
		cs_n <= 1'b0;
		rd(expw(8 * (nconv - 1)), -1);
		@(posedge clock);
		cs_n <= 1'b1;
		stall <= 1'b0;
		wait_on(1'b0, 1'b0);
		cyc(30);
		chk(busy, 1'b0);
		start(1'b0, 1'b0);
		{isel, bsel, bord} <= 3'h7;
		cyc(8);
		frame(nconv++, 1'b1, 1'b1);
		bord <= 1'b0;
		convert();
		frame(nconv++, 1'b1, 1'b0);
		$display("test groups and byte mode done");
	endtask : t_groups
	task automatic t_serial;
		bsel <= 1'b0;
		convert();
		nconv++;
		{cs_n, rd_n} <= 2'b00;
		cyc(8);
		chk({loe, moe}, 2'b00);
		{cs_n, rd_n} <= 2'b11;
		{isel, bsel} <= 2'b00;
		cyc(8);
		$display("test serial done");
	endtask : t_serial
	task automatic t_fill;
		flood <= 1'b1;
		@(posedge clock);
		flood <= 1'b0;
		wait_on(1'b1, 1'b0);
		cyc(4);
		chk(pc, 8 * nconv + FIFO_DEPTH);
		convert();
		frame(nconv++, 1'b0, 1'b0);
		$display("test fill done");
	endtask : t_fill
	task automatic t_power;
		{pd_n, rng} <= 2'b01;
		cyc(8);
		chk({fe, rf}, 2'b10);
		rng <= 1'b0;
		cyc(8);
		chk({fe, rf}, 2'b11);
		{pd_n, rng} <= 2'b11;
		stall <= 1'b1;
		cyc(8);
		start(1'b1, 1'b1);
		wait_on(1'b0, 1'b1);
		pd_n <= 1'b0;
		cyc(8);
		chk({busy, fe}, 2'b01);
		start(1'b0, 1'b0);
		pd_n <= 1'b1;
		stall <= 1'b0;
		// short settle stands in for the long exit delay
		cyc(20);
		rst_b <= 1'b0;
		cyc(4);
		rst_b <= 1'b1;
		cyc(4);
		convert();
		frame(0, 1'b0, 1'b0);
		$display("test power done");
	endtask : t_power

	initial begin
		{sa, sb, stall, flood} = 4'h0;
		{cs_n, rd_n, pd_n, rng} = 4'hF;
		{isel, bsel, bord} = 3'h0;
		rst_b = 1'b0;
		cyc(10);
		rst_b <= 1'b1;
		cyc(4);
		t_combined();
		t_groups();
		t_serial();
		t_fill();
		t_power();
		test_done();
	end
endmodule : testbench
